//--- verilog/flash_prot_map.svh
// Offsets, field positions, reset values and timing counts of the array write-protection block.
`ifndef FLASH_PROT_MAP_SVH
`define FLASH_PROT_MAP_SVH

// Array geometry: address bit positions and widths, sector count and the erased byte value.
`define ADDR_W            24
`define PAGE_LSB          8
`define SUBSECTOR_LSB     12
`define SECTOR_LSB        16
`define SECTOR_COUNT      256
`define SECTOR_IDX_W      8
`define OTP_ADDR_W        6
`define ERASED_BYTE       8'hFF

// Block-protect decode limits.
`define PROTECT_NONE      4'h0
`define PROTECT_MAX_SIZE  4'h8
`define PROTECT_ALL_SPAN  9'h100

// Register port offsets.
`define REG_STATUS        8'h00
`define REG_LOCK_SEL      8'h01
`define REG_LOCK_VIEW     8'h02
`define REG_REFUSE_CAUSE  8'h03
`define REG_REFUSE_COUNT  8'h04

// Status register fields.
`define ST_SUPPLY_READY   0
`define ST_WEL            1
`define ST_PSIZE_LSB      2
`define ST_PSIZE_MSB      5
`define ST_FROM_BOTTOM    6

// Lock view fields, also the data layout of a lock-register write command.
`define LK_WRITE_LOCK     0
`define LK_LOCK_DOWN      1

// Refusal cause fields.
`define RC_POWER          0
`define RC_COUNT          1
`define RC_WEL            2
`define RC_SECTOR_LOCK    3
`define RC_BLOCK_PROTECT  4
`define RC_LOCK_DOWN      5

// Reset values.
`define PSIZE_RESET       4'h0
`define FROM_BOTTOM_RESET 1'b0
`define LOCK_SEL_RESET    8'h00

// Supply settle time after the supply-good pin rises.
`define CLK_MHZ           125
`define PWR_WAIT_NS       10000
`define PWR_WAIT_CYC      ((`PWR_WAIT_NS * `CLK_MHZ + 999) / 1000)

`endif

//--- verilog/flash_prot_pkg.sv
// Types shared by the array write-protection block.
package flash_prot_pkg;

    typedef enum logic [3:0] {
        OP_NONE          = 4'h0,
        OP_WRITE_ENABLE  = 4'h1,
        OP_WRITE_DISABLE = 4'h2,
        OP_PROGRAM       = 4'h3,
        OP_ERASE_SUB     = 4'h4,
        OP_ERASE_SECTOR  = 4'h5,
        OP_ERASE_CHIP    = 4'h6,
        OP_OTP_PROGRAM   = 4'h7,
        OP_WRITE_STATUS  = 4'h8,
        OP_WRITE_LOCK    = 4'h9
    } op_t;

endpackage : flash_prot_pkg

//--- verilog/block_protect_decode.sv
// Decodes the block-protect field into a protected-sector test for one sector.
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_map.svh"

module block_protect_decode (
    input  wire logic [3:0]                 protect_size,
    input  wire logic                       protect_from_bottom_select,
    input  wire logic [`SECTOR_IDX_W-1:0]   sector,
    output logic                            hit
);

    logic [8:0] span;
    logic [8:0] sector_w;

    assign sector_w = {1'b0, sector};

    always_comb begin
        if (protect_size == `PROTECT_NONE) begin
            span = 9'h000;
        end else if (protect_size > `PROTECT_MAX_SIZE) begin
            span = `PROTECT_ALL_SPAN;
        end else begin
            span = 9'h001 << (protect_size - 4'h1);
        end
    end

    always_comb begin
        if (span == 9'h000) begin
            hit = 1'b0;
        end else if (protect_from_bottom_select) begin
            hit = (sector_w < span);
        end else begin
            hit = (sector_w >= (`PROTECT_ALL_SPAN - span));
        end
    end

endmodule : block_protect_decode
`default_nettype wire

//--- verilog/flash_array_write_protection.sv
// Address decode and program/erase permission check for a serial NOR flash array.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_map.svh"

module flash_array_write_protection #(
    parameter int unsigned PWR_WAIT_CYC = `PWR_WAIT_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       supply_ok,
    input  wire logic                       cmd_valid,
    input  wire flash_prot_pkg::op_t        cmd_op,
    input  wire logic [`ADDR_W-1:0]         cmd_addr,
    input  wire logic [2:0]                 cmd_pulse_count,
    input  wire logic [7:0]                 cmd_data,
    input  wire logic [7:0]                 cell_data,
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [7:0]                      reg_rdata,
    output logic                            exec_grant,
    output logic                            exec_refuse,
    output flash_prot_pkg::op_t             exec_op,
    output logic [15:0]                     exec_page,
    output logic [11:0]                     exec_subsector,
    output logic [`SECTOR_IDX_W-1:0]        exec_sector,
    output logic [`ADDR_W-1:0]              exec_start,
    output logic [`ADDR_W-1:0]              exec_end,
    output logic [7:0]                      exec_wdata,
    output logic                            exec_otp,
    output logic [`OTP_ADDR_W-1:0]          exec_otp_addr,
    output logic                            write_enable_latch,
    output logic                            supply_ready
);

    import flash_prot_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Supply monitor.

    logic        supply_meta_q;
    logic        supply_sync_q;
    logic [15:0] settle_cnt_q;
    logic        ready_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            supply_meta_q <= 1'b0;
            supply_sync_q <= 1'b0;
        end else begin
            supply_meta_q <= supply_ok;
            supply_sync_q <= supply_meta_q;
        end
    end

    // The settle timer restarts on every dip so a glitching supply never opens the array.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            settle_cnt_q <= 16'h0000;
            ready_q      <= 1'b0;
        end else if (!supply_sync_q) begin
            settle_cnt_q <= 16'h0000;
            ready_q      <= 1'b0;
        end else if (settle_cnt_q >= 16'(PWR_WAIT_CYC - 1)) begin
            ready_q      <= 1'b1;
        end else begin
            settle_cnt_q <= settle_cnt_q + 16'h0001;
        end
    end

    assign supply_ready = ready_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode.

    logic [`SECTOR_IDX_W-1:0] sector;
    logic [11:0]              subsector;
    logic [15:0]              page;

    assign sector    = cmd_addr[`ADDR_W-1:`SECTOR_LSB];
    assign subsector = cmd_addr[`ADDR_W-1:`SUBSECTOR_LSB];
    assign page      = cmd_addr[`ADDR_W-1:`PAGE_LSB];

    ////////////////////////////////////////////////////////////////////////////////
    // Protection state.

    logic                      wel_q;
    logic [3:0]                psize_q;
    logic                      from_bottom_q;
    logic [`SECTOR_COUNT-1:0]  wlock_q;
    logic [`SECTOR_COUNT-1:0]  ldown_q;
    logic                      bp_hit;

    block_protect_decode u_bp_decode (
        .protect_size               (psize_q),
        .protect_from_bottom_select (from_bottom_q),
        .sector                     (sector),
        .hit                        (bp_hit)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Command check.

    logic       is_modify;
    logic       is_array;
    logic       is_chip;
    logic [5:0] cause;
    logic       refuse;
    logic       grant;

    always_comb begin
        is_modify = 1'b0;
        is_array  = 1'b0;
        is_chip   = 1'b0;
        unique case (cmd_op)
            OP_NONE: begin
            end
            OP_WRITE_ENABLE, OP_WRITE_DISABLE: begin
            end
            OP_PROGRAM, OP_ERASE_SUB, OP_ERASE_SECTOR: begin
                is_modify = 1'b1;
                is_array  = 1'b1;
            end
            OP_ERASE_CHIP: begin
                is_modify = 1'b1;
                is_array  = 1'b1;
                is_chip   = 1'b1;
            end
            OP_OTP_PROGRAM, OP_WRITE_STATUS, OP_WRITE_LOCK: begin
                is_modify = 1'b1;
            end
            default: begin
            end
        endcase
    end

    always_comb begin
        cause = 6'h00;
        cause[`RC_POWER]         = is_modify & ~ready_q;
        cause[`RC_COUNT]         = (cmd_op != OP_NONE) & (cmd_pulse_count != 3'h0);
        cause[`RC_WEL]           = is_modify & ~wel_q;
        cause[`RC_SECTOR_LOCK]   = is_array & (is_chip ? (|wlock_q) : wlock_q[sector]);
        cause[`RC_BLOCK_PROTECT] = is_array
                                 & (is_chip ? (psize_q != `PROTECT_NONE) : bp_hit);
        cause[`RC_LOCK_DOWN]     = (cmd_op == OP_WRITE_LOCK) & ldown_q[sector];
    end

    assign refuse = cmd_valid & (cmd_op != OP_NONE) & (|cause);
    assign grant  = cmd_valid & (cmd_op != OP_NONE) & ~(|cause);

    ////////////////////////////////////////////////////////////////////////////////
    // Write enable latch and status fields.

    // A granted modify consumes the latch; only one command arrives per cycle,
    // so a set and a clear can never meet.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wel_q <= 1'b0;
        end else if (grant && cmd_op == OP_WRITE_ENABLE) begin
            wel_q <= 1'b1;
        end else if (grant && (cmd_op == OP_WRITE_DISABLE || is_modify)) begin
            wel_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            psize_q       <= `PSIZE_RESET;
            from_bottom_q <= `FROM_BOTTOM_RESET;
        end else if (grant && cmd_op == OP_WRITE_STATUS) begin
            psize_q       <= cmd_data[`ST_PSIZE_MSB:`ST_PSIZE_LSB];
            from_bottom_q <= cmd_data[`ST_FROM_BOTTOM];
        end
    end

    assign write_enable_latch = wel_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Sector lock bits, one pair per sector.

    generate
        for (genvar s = 0; s < `SECTOR_COUNT; s++) begin : g_lock
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    wlock_q[s] <= 1'b0;
                    ldown_q[s] <= 1'b0;
                end else if (grant && cmd_op == OP_WRITE_LOCK
                             && sector == `SECTOR_IDX_W'(s)) begin
                    wlock_q[s] <= cmd_data[`LK_WRITE_LOCK];
                    ldown_q[s] <= cmd_data[`LK_LOCK_DOWN];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Execution outputs.

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            exec_grant  <= 1'b0;
            exec_refuse <= 1'b0;
        end else begin
            exec_grant  <= grant;
            exec_refuse <= refuse;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            exec_op        <= OP_NONE;
            exec_page      <= 16'h0000;
            exec_subsector <= 12'h000;
            exec_sector    <= 8'h00;
            exec_start     <= 24'h000000;
            exec_end       <= 24'h000000;
            exec_wdata     <= 8'h00;
            exec_otp       <= 1'b0;
            exec_otp_addr  <= 6'h00;
        end else if (cmd_valid) begin
            exec_op        <= cmd_op;
            exec_page      <= page;
            exec_subsector <= subsector;
            exec_sector    <= sector;
            exec_otp       <= (cmd_op == OP_OTP_PROGRAM);
            exec_otp_addr  <= (cmd_op == OP_OTP_PROGRAM)
                            ? cmd_addr[`OTP_ADDR_W-1:0] : 6'h00;
            exec_wdata     <= cmd_data;
            exec_start     <= cmd_addr;
            exec_end       <= cmd_addr;
            unique case (cmd_op)
                OP_PROGRAM: begin
                    exec_wdata <= cmd_data & cell_data;
                    exec_start <= {page, 8'h00};
                    exec_end   <= {page, 8'hFF};
                end
                OP_OTP_PROGRAM: begin
                    exec_wdata <= cmd_data & cell_data;
                    exec_start <= 24'h000000;
                    exec_end   <= 24'h000000;
                end
                OP_ERASE_SUB: begin
                    exec_wdata <= `ERASED_BYTE;
                    exec_start <= {subsector, 12'h000};
                    exec_end   <= {subsector, 12'hFFF};
                end
                OP_ERASE_SECTOR: begin
                    exec_wdata <= `ERASED_BYTE;
                    exec_start <= {sector, 16'h0000};
                    exec_end   <= {sector, 16'hFFFF};
                end
                OP_ERASE_CHIP: begin
                    exec_wdata <= `ERASED_BYTE;
                    exec_start <= 24'h000000;
                    exec_end   <= 24'hFFFFFF;
                end
                OP_NONE, OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_WRITE_STATUS,
                OP_WRITE_LOCK: begin
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Refusal record.

    logic [5:0] cause_q;
    logic [7:0] refuse_cnt_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cause_q <= 6'h00;
        end else if (refuse) begin
            cause_q <= cause;
        end
    end

    // The count saturates so software can tell a flood of refusals from a wrap.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            refuse_cnt_q <= 8'h00;
        end else if (refuse && refuse_cnt_q != 8'hFF) begin
            refuse_cnt_q <= refuse_cnt_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port.

    logic [`SECTOR_IDX_W-1:0] lock_sel_q;
    logic [7:0]               rdata_d;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_sel_q <= `LOCK_SEL_RESET;
        end else if (reg_wr && reg_addr == `REG_LOCK_SEL) begin
            lock_sel_q <= reg_wdata;
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            `REG_STATUS: begin
                rdata_d[`ST_SUPPLY_READY]              = ready_q;
                rdata_d[`ST_WEL]                       = wel_q;
                rdata_d[`ST_PSIZE_MSB:`ST_PSIZE_LSB]   = psize_q;
                rdata_d[`ST_FROM_BOTTOM]               = from_bottom_q;
            end
            `REG_LOCK_SEL: begin
                rdata_d = lock_sel_q;
            end
            `REG_LOCK_VIEW: begin
                rdata_d[`LK_WRITE_LOCK] = wlock_q[lock_sel_q];
                rdata_d[`LK_LOCK_DOWN]  = ldown_q[lock_sel_q];
            end
            `REG_REFUSE_CAUSE: begin
                rdata_d = {2'b00, cause_q};
            end
            `REG_REFUSE_COUNT: begin
                rdata_d = refuse_cnt_q;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe and return to zero.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : flash_array_write_protection
`default_nettype wire

//--- test/flash_prot_properties.sv
// Port-level assertions for the array write-protection block.
`timescale 1ns/1ps
`default_nettype none

module flash_prot_properties #(
    parameter int unsigned PWR_WAIT_CYC = 4
) (
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic                 supply_ok,
    input wire logic                 cmd_valid,
    input wire flash_prot_pkg::op_t  cmd_op,
    input wire logic [23:0]          cmd_addr,
    input wire logic [2:0]           cmd_pulse_count,
    input wire logic [7:0]           cmd_data,
    input wire logic [7:0]           cell_data,
    input wire logic                 exec_grant,
    input wire logic                 exec_refuse,
    input wire flash_prot_pkg::op_t  exec_op,
    input wire logic [15:0]          exec_page,
    input wire logic [11:0]          exec_subsector,
    input wire logic [7:0]           exec_sector,
    input wire logic [7:0]           exec_wdata,
    input wire logic                 exec_otp,
    input wire logic [5:0]           exec_otp_addr,
    input wire logic                 write_enable_latch,
    input wire logic                 supply_ready
);
    import flash_prot_pkg::*;

    logic modify;
    assign modify = cmd_valid && (cmd_op inside {OP_PROGRAM, OP_ERASE_SUB, OP_ERASE_SECTOR,
        OP_ERASE_CHIP, OP_OTP_PROGRAM, OP_WRITE_STATUS, OP_WRITE_LOCK});

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_answer_once: assert property (cmd_valid && cmd_op != OP_NONE |=> exec_grant ^ exec_refuse)
        else $error("command not answered by exactly one of grant or refuse");
    a_idle_silent: assert property (!cmd_valid |=> !exec_grant && !exec_refuse)
        else $error("answer without a command");
    a_count_refuse: assert property (cmd_valid && cmd_op != OP_NONE
        && cmd_pulse_count != 3'h0 |=> exec_refuse)
        else $error("partial byte command not refused");
    a_power_refuse: assert property (modify && !supply_ready |=> exec_refuse)
        else $error("modify granted while supply not ready");
    a_wel_refuse: assert property (modify && !write_enable_latch |=> exec_refuse)
        else $error("modify granted with latch clear");
    a_wren_sets: assert property (cmd_valid && cmd_op == OP_WRITE_ENABLE
        && cmd_pulse_count == 3'h0 |=> exec_grant && write_enable_latch)
        else $error("write enable did not set the latch");
    a_program_clears: assert property (cmd_valid && cmd_op == OP_PROGRAM
        |=> exec_wdata == ($past(cmd_data) & $past(cell_data)))
        else $error("program data could set a bit");
    a_erase_fills: assert property (exec_grant
        && exec_op inside {OP_ERASE_SUB, OP_ERASE_SECTOR, OP_ERASE_CHIP}
        |-> exec_wdata == 8'hFF)
        else $error("erase data not all ones");
    a_addr_decode: assert property (cmd_valid && cmd_op == OP_PROGRAM
        |=> exec_page == 16'($past(cmd_addr) >> 8) && exec_subsector == 12'($past(cmd_addr) >> 12)
        && exec_sector == 8'($past(cmd_addr) >> 16))
        else $error("address split wrong");
    a_otp_apart: assert property (cmd_valid && cmd_op == OP_OTP_PROGRAM
        |=> exec_otp && exec_otp_addr == 6'($past(cmd_addr)))
        else $error("one-time area address wrong");
    a_supply_drop: assert property (!supply_ok [*4] |=> !supply_ready)
        else $error("ready kept after supply loss");

    c_program: cover property (cmd_valid && cmd_op == OP_PROGRAM ##1 exec_grant);
    c_refuse: cover property (modify ##1 exec_refuse);
    c_chip: cover property (cmd_valid && cmd_op == OP_ERASE_CHIP ##1 exec_grant);

endmodule : flash_prot_properties

bind flash_array_write_protection flash_prot_properties #(.PWR_WAIT_CYC(PWR_WAIT_CYC)) u_props (
    .clk(clk), .rst_b(rst_b), .supply_ok(supply_ok), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_pulse_count(cmd_pulse_count), .cmd_data(cmd_data),
    .cell_data(cell_data), .exec_grant(exec_grant), .exec_refuse(exec_refuse),
    .exec_op(exec_op), .exec_page(exec_page), .exec_subsector(exec_subsector),
    .exec_sector(exec_sector), .exec_wdata(exec_wdata), .exec_otp(exec_otp),
    .exec_otp_addr(exec_otp_addr), .write_enable_latch(write_enable_latch),
    .supply_ready(supply_ready)
);

`default_nettype wire

//--- test/spi_master_model.sv
// Command source standing in for the serial bus master and its command decoder.
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
    input  wire logic                clk,
    output logic                     cmd_valid,
    output var flash_prot_pkg::op_t  cmd_op,
    output logic [23:0]              cmd_addr,
    output logic [2:0]               cmd_pulse_count,
    output logic [7:0]               cmd_data
);
    import flash_prot_pkg::*;

    initial begin
        {cmd_valid, cmd_addr, cmd_pulse_count, cmd_data} = '0;
        cmd_op = OP_NONE;
    end

    // One command cycle; between commands the address and data lines hold the complement of the last command's values.
    task automatic send(input op_t op, input logic [23:0] a, input logic [7:0] d,
                        input logic [2:0] n);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_pulse_count <= n;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_op <= OP_NONE;
        cmd_addr <= ~a;
        cmd_data <= ~d;
    endtask : send

    // A modifying command sent through this task is preceded by a write enable.
    task automatic modify(input op_t op, input logic [23:0] a, input logic [7:0] d,
                          input logic [2:0] n);
        send(OP_WRITE_ENABLE, 24'h000000, 8'h00, 3'h0);
        send(op, a, d, n);
    endtask : modify

endmodule : spi_master_model

`default_nettype wire

//--- test/testbench.sv
// Self-checking testbench for the array write-protection block.
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_map.svh"

module testbench;
    import flash_prot_pkg::*;

    logic        clk, rst_b, supply_ok, cmd_valid, reg_wr, reg_rd;
    op_t         cmd_op, exec_op;
    logic [23:0] cmd_addr, exec_start, exec_end;
    logic [2:0]  cmd_pulse_count;
    logic [7:0]  cmd_data, cell_data, reg_addr, reg_wdata, reg_rdata, exec_sector, exec_wdata;
    logic        exec_grant, exec_refuse, exec_otp, write_enable_latch, supply_ready, prot;
    logic [15:0] exec_page;
    logic [11:0] exec_subsector;
    logic [5:0]  exec_otp_addr;
    int          error_cnt, compares, p, bnd;

    flash_array_write_protection #(.PWR_WAIT_CYC(4)) dut (
        .clk(clk), .rst_b(rst_b), .supply_ok(supply_ok), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_pulse_count(cmd_pulse_count),
        .cmd_data(cmd_data), .cell_data(cell_data), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .exec_grant(exec_grant), .exec_refuse(exec_refuse), .exec_op(exec_op),
        .exec_page(exec_page), .exec_subsector(exec_subsector), .exec_sector(exec_sector),
        .exec_start(exec_start), .exec_end(exec_end), .exec_wdata(exec_wdata),
        .exec_otp(exec_otp), .exec_otp_addr(exec_otp_addr),
        .write_enable_latch(write_enable_latch), .supply_ready(supply_ready));

    spi_master_model u_master (
        .clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_pulse_count(cmd_pulse_count), .cmd_data(cmd_data));

    always #4 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, {16'h0, exp}, {16'h0, reg_rdata});
    endtask : reg_check

    // Sends one command, with a write enable first when asked, and checks the answer.
    task automatic run(input op_t op, input logic [23:0] a, input logic [7:0] d,
                       input logic [2:0] n, input logic wren, input logic g);
        if (wren) begin
            u_master.modify(op, a, d, n);
        end else begin
            u_master.send(op, a, d, n);
        end
        #1;
        chk("grant", {23'h0, g}, {23'h0, exec_grant});
        chk("refuse", {23'h0, !g}, {23'h0, exec_refuse});
    endtask : run

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        supply_ok = 1'b0;
        cell_data = 8'h3C;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        reg_check("status", `REG_STATUS, 8'h00);
        run(OP_PROGRAM, 24'h000100, 8'h00, 3'h0, 1'b1, 1'b0);
        reg_check("cause", `REG_REFUSE_CAUSE, 8'h01);
        reg_check("status", `REG_STATUS, 8'h02);
        @(posedge clk) supply_ok <= 1'b1;
        for (int i = 0; i <= 50 && supply_ready !== 1'b1; i++) begin
            if (i == 50) begin
                error_cnt++;
                finish_test();
            end
            @(posedge clk);
        end
        run(OP_PROGRAM, 24'h000100, 8'h00, 3'h4, 1'b0, 1'b0);
        reg_check("cause", `REG_REFUSE_CAUSE, 8'h02);
        run(OP_PROGRAM, 24'h7FF123, 8'h5A, 3'h0, 1'b0, 1'b1);
        chk("wdata", 24'h000018, {16'h0, exec_wdata});
        chk("page", 24'h007FF1, {8'h0, exec_page});
        chk("subsector", 24'h0007FF, {12'h0, exec_subsector});
        chk("start", 24'h7FF100, exec_start);
        chk("end", 24'h7FF1FF, exec_end);
        run(OP_PROGRAM, 24'h7FF123, 8'h5A, 3'h0, 1'b0, 1'b0);
        reg_check("cause", `REG_REFUSE_CAUSE, 8'h04);
        run(OP_ERASE_SUB, 24'h123456, 8'h00, 3'h0, 1'b1, 1'b1);
        chk("start", 24'h123000, exec_start);
        chk("end", 24'h123FFF, exec_end);
        chk("wdata", 24'h0000FF, {16'h0, exec_wdata});
        run(OP_ERASE_SECTOR, 24'h123456, 8'h00, 3'h0, 1'b1, 1'b1);
        chk("start", 24'h120000, exec_start);
        chk("end", 24'h12FFFF, exec_end);
        run(OP_OTP_PROGRAM, 24'hABCD25, 8'h00, 3'h0, 1'b1, 1'b1);
        chk("otp", 24'h000065, {17'h0, exec_otp, exec_otp_addr});
        reg_write(`REG_STATUS, 8'hFF);
        reg_check("status", `REG_STATUS, 8'h01);
        reg_check("unmapped", 8'h40, 8'h00);
        for (int tb = 0; tb < 2; tb++) begin
            for (int sz = 0; sz < 16; sz++) begin
                p = (sz == 0) ? 0 : (sz > 8) ? 256 : 1 << (sz - 1);
                run(OP_WRITE_STATUS, 24'h0, {1'b0, tb[0], sz[3:0], 2'b00}, 3'h0, 1'b1, 1'b1);
                reg_check("status", `REG_STATUS, {1'b0, tb[0], sz[3:0], 2'b01});
                bnd = (tb == 1) ? p : 256 - p;
                for (int s = bnd - 1; s <= bnd; s++) begin
                    if (s >= 0 && s < 256) begin
                        prot = (tb == 1) ? (s < p) : (s >= 256 - p);
                        run(OP_ERASE_SECTOR, {s[7:0], 16'h0}, 8'h00, 3'h0, 1'b1, !prot);
                    end
                end
                run(OP_ERASE_CHIP, 24'h0, 8'h00, 3'h0, 1'b1, p == 0);
            end
        end
        run(OP_WRITE_STATUS, 24'h0, 8'h00, 3'h0, 1'b1, 1'b1);
        run(OP_WRITE_LOCK, 24'h050000, 8'h01, 3'h0, 1'b1, 1'b1);
        reg_write(`REG_LOCK_SEL, 8'h05);
        reg_write(`REG_LOCK_VIEW, 8'h03);
        reg_check("lock", `REG_LOCK_VIEW, 8'h01);
        run(OP_PROGRAM, 24'h05ABCD, 8'h00, 3'h0, 1'b1, 1'b0);
        reg_check("cause", `REG_REFUSE_CAUSE, 8'h08);
        run(OP_ERASE_CHIP, 24'h0, 8'h00, 3'h0, 1'b1, 1'b0);
        run(OP_ERASE_SECTOR, 24'h060000, 8'h00, 3'h0, 1'b1, 1'b1);
        run(OP_WRITE_LOCK, 24'h050000, 8'h02, 3'h0, 1'b1, 1'b1);
        run(OP_WRITE_LOCK, 24'h050000, 8'h01, 3'h0, 1'b1, 1'b0);
        reg_check("cause", `REG_REFUSE_CAUSE, 8'h20);
        reg_check("lock", `REG_LOCK_VIEW, 8'h02);
        run(OP_PROGRAM, 24'h05ABCD, 8'h00, 3'h0, 1'b1, 1'b1);
        reg_check("count", `REG_REFUSE_COUNT, 8'h42);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        reg_write(`REG_LOCK_SEL, 8'h05);
        reg_check("lock", `REG_LOCK_VIEW, 8'h00);
        finish_test();
    end

endmodule : testbench

`default_nettype wire
